// ### crtb_pkg.sv
// Package: constants and types for the clock, reset and timebase block
package crtb_pkg;
	// Register map (byte addresses)
	localparam logic [9:0] IDX_STANDBY_OSC = 10'h0db;
	localparam logic [11:0] ADDR_STANDBY_OSC = {IDX_STANDBY_OSC, 2'b00};
	localparam logic [11:0] ADDR_RESET_CTRL = 12'h0e0;
	localparam logic [11:0] ADDR_RESET_STAT = 12'h0e4;
	// Standby oscillator register fields
	localparam int IRQ_EN_BIT = 7;
	localparam int ELAPSED_BIT = 6;
	localparam int RUN_BIT = 5;
	localparam logic [7:0] STANDBY_OSC_RST = 8'h00;
	// Reset control register fields
	localparam int CTRL_RETURN_FROM_INTERRUPT_BIT = 0;
	localparam int CTRL_IRQ_PEND_BIT = 1;
	localparam int CTRL_STOP_BIT = 2;
	localparam int CTRL_WAIT_BIT = 3;
	localparam logic [3:0] RESET_CTRL_RST = 4'h0;
	// Dividers and timing
	localparam int CORE_DIV = 13;
	localparam int CONV_DIV = 12;
	localparam int TB_BITS = 14;
	localparam int STAB_CYCLES = 2048;
	localparam logic [11:0] RESET_VECTOR = 12'hffe;
	localparam int STACK_DEPTH = 6;
	// Reset sequencer states
	typedef enum logic [1:0] {
		CRTB_HOLD = 2'b00,
		CRTB_STAB = 2'b01,
		CRTB_INIT = 2'b10,
		CRTB_RUN = 2'b11
	} crtb_state_t;
	// Standby oscillator register image
	typedef struct packed {
		logic irq_en;
		logic elapsed;
		logic run;
		logic [4:0] spare;
	} crtb_osc_t;
	// Signals handed to the CPU core
	typedef struct packed {
		logic core_reset;
		logic nmi_context;
		logic stack_clear;
		logic pc_load;
		logic pullup_inputs;
		logic osc_restart;
	} crtb_core_t;
endpackage : crtb_pkg

// ### crtb_top.sv
// Clock dividers, standby timebase and reset sequencer with APB registers
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// [RQ1] Machine cycle is internal clock over 13; converter clock over 12.
// [RQ2] Standby clock goes to LCD while the standby oscillator runs.
// [RQ3] Timebase divider wraps every 2^14 inputs and raises an event.
// [RQ4] Oscillator stopped: divider counts machine cycles instead.
// [RQ5] Timebase request reaches CPU only with enable bit 7 set.
// [RQ6] Elapsed flag bit 6 sets at every timebase wrap.
// [RQ7] Software clears the elapsed flag before leaving its handler.
// [RQ8] Run bit 5 starts standby oscillator and selects it for divider.
// [RQ9] Every reset clears the whole standby oscillator register.
// [RQ10] Reset comes from pin low, power-on or watchdog timeout.
// [RQ11] Pin reset accepted in any mode, stretched, held while low.
// [RQ12] Reset in run or wait halts code, pulls up pins, restarts osc.
// [RQ13] Reset in stop starts oscillator and pulls up pins first.
// [RQ14] Internal reset ends 2048 clocks after external release.
// [RQ15] Power-on: no execution, pins pulled up, delay once osc runs.
// [RQ16] Watchdog end-of-count resets, clears watchdog, full delay.
// [RQ17] Leaving reset clears stack and loads the reset vector.
// [RQ18] Start in NMI context until the first return from interrupt.
// [RQ19] At that return, pending interrupt is served, else continue.
// [RQ20] Software stops standby oscillator before stop for low power.
// [RQ21] Timebase request equals flag AND enable, held as a level.
module crtb_top #(
	parameter int STAB_COUNT = crtb_pkg::STAB_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_reset_n,
	input wire logic i_por,
	input wire logic i_osc_ready,
	input wire logic i_wdog_timeout,
	input wire logic i_standby_xtal_input,
	output logic o_standby_xtal_output,
	output logic o_machine_clk,
	output logic o_conv_clk,
	output logic o_lcd_clk,
	output logic o_timebase_irq,
	output logic o_wdog_clear,
	output logic o_main_osc_on,
	output crtb_pkg::crtb_core_t o_core,
	output logic [11:0] o_pc_load_value,
	output logic o_service_pending
);
	localparam int SC_W = $clog2(STAB_COUNT + 1);
	localparam logic [SC_W-1:0] SC_END = SC_W'(STAB_COUNT - 1);
	localparam int TBW = crtb_pkg::TB_BITS;

	crtb_pkg::crtb_osc_t osc_r;
	crtb_pkg::crtb_state_t state_r;
	logic [3:0] ctrl_r;
	logic [3:0] div13_r;
	logic [3:0] div12_r;
	logic mc_tick;
	logic [2:0] rst_sync_r;
	logic [2:0] xtal_sync_r;
	logic [2:0] por_sync_r;
	logic [2:0] oscok_sync_r;
	logic pin_low_r;
	logic xtal_lvl_r;
	logic por_r;
	logic osc_ok_r;
	logic xtal_rise;
	logic [crtb_pkg::TB_BITS-1:0] tb_r;
	logic tb_tick;
	logic tb_wrap;
	logic [SC_W-1:0] stab_r;
	logic any_reset;
	logic stop_seen_r;
	logic apb_wr;
	logic sw_clear_flag;
	logic return_from_interrupt_pulse;

	// Clock dividers
	assign mc_tick = (div13_r == 4'(crtb_pkg::CORE_DIV - 1)); // RQ1
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div13_r <= 4'h0;
			o_machine_clk <= 1'b0;
		end else begin
			div13_r <= mc_tick ? 4'h0 : div13_r + 4'h1; // RQ1
			o_machine_clk <= (div13_r < 4'(crtb_pkg::CORE_DIV / 2)); // RQ1
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div12_r <= 4'h0;
			o_conv_clk <= 1'b0;
		end else begin
			if (div12_r == 4'(crtb_pkg::CONV_DIV - 1)) begin
				div12_r <= 4'h0; // RQ1
			end else begin
				div12_r <= div12_r + 4'h1;
			end
			o_conv_clk <= (div12_r < 4'(crtb_pkg::CONV_DIV / 2)); // RQ1
		end
	end

	// Input synchronisers, three stages, change when stages 2 and 3 agree
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rst_sync_r <= 3'h0;
			xtal_sync_r <= 3'h0;
			por_sync_r <= 3'h7;
			oscok_sync_r <= 3'h0;
			pin_low_r <= 1'b1;
			xtal_lvl_r <= 1'b0;
			por_r <= 1'b1;
			osc_ok_r <= 1'b0;
		end else begin
			rst_sync_r <= {rst_sync_r[1:0], i_reset_n};
			xtal_sync_r <= {xtal_sync_r[1:0], i_standby_xtal_input};
			por_sync_r <= {por_sync_r[1:0], i_por};
			oscok_sync_r <= {oscok_sync_r[1:0], i_osc_ready};
			if (rst_sync_r[2] == rst_sync_r[1]) begin
				pin_low_r <= ~rst_sync_r[2];
			end
			if (xtal_sync_r[2] == xtal_sync_r[1]) begin
				xtal_lvl_r <= xtal_sync_r[2];
			end
			if (por_sync_r[2] == por_sync_r[1]) begin
				por_r <= por_sync_r[2];
			end
			if (oscok_sync_r[2] == oscok_sync_r[1]) begin
				osc_ok_r <= oscok_sync_r[2];
			end
		end
	end
	assign xtal_rise = xtal_sync_r[2] & xtal_sync_r[1] & ~xtal_lvl_r;

	// Standby oscillator drive and LCD clock
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_standby_xtal_output <= 1'b0;
			o_lcd_clk <= 1'b0;
		end else begin
			o_standby_xtal_output <= osc_r.run & ~xtal_lvl_r; // RQ8
			o_lcd_clk <= osc_r.run & xtal_lvl_r; // RQ2
		end
	end

	// Timebase divider
	assign tb_tick = osc_r.run ? xtal_rise : mc_tick; // RQ4 RQ8
	assign tb_wrap = tb_tick & (&tb_r); // RQ3
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tb_r <= '0;
		end else if (tb_tick) begin
			tb_r <= tb_r + TBW'(1); // RQ3
		end
	end

	// APB decode
	assign apb_wr = i_psel & i_penable & i_pwrite;
	assign sw_clear_flag = apb_wr && (i_paddr == crtb_pkg::ADDR_STANDBY_OSC)
		&& !i_pwdata[crtb_pkg::ELAPSED_BIT];
	assign return_from_interrupt_pulse = apb_wr && (i_paddr == crtb_pkg::ADDR_RESET_CTRL)
		&& i_pwdata[crtb_pkg::CTRL_RETURN_FROM_INTERRUPT_BIT];

	// Standby oscillator register; set of flag wins over clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			osc_r <= crtb_pkg::STANDBY_OSC_RST;
		end else if (any_reset) begin
			osc_r <= crtb_pkg::STANDBY_OSC_RST; // RQ9
		end else begin
			if (apb_wr && i_paddr == crtb_pkg::ADDR_STANDBY_OSC) begin
				osc_r.irq_en <= i_pwdata[crtb_pkg::IRQ_EN_BIT];
				osc_r.run <= i_pwdata[crtb_pkg::RUN_BIT]; // RQ8
				osc_r.spare <= i_pwdata[4:0];
			end
			if (tb_wrap) begin
				osc_r.elapsed <= 1'b1; // RQ6
			end else if (sw_clear_flag) begin
				osc_r.elapsed <= 1'b0; // RQ7
			end
		end
	end

	// Timebase interrupt level
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_timebase_irq <= 1'b0;
		end else begin
			o_timebase_irq <= osc_r.elapsed & osc_r.irq_en; // RQ5 RQ21
		end
	end

	// Mode and return control register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_r <= crtb_pkg::RESET_CTRL_RST;
		end else if (any_reset) begin
			ctrl_r <= crtb_pkg::RESET_CTRL_RST;
		end else if (apb_wr && i_paddr == crtb_pkg::ADDR_RESET_CTRL) begin
			ctrl_r <= {i_pwdata[3:1], 1'b0};
		end
	end

	// Reset sequencer
	assign any_reset = pin_low_r | por_r | i_wdog_timeout; // RQ10 RQ16
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= crtb_pkg::CRTB_HOLD;
			stab_r <= '0;
		end else if (any_reset) begin
			state_r <= crtb_pkg::CRTB_HOLD; // RQ11
			stab_r <= '0;
		end else begin
			case (state_r)
				crtb_pkg::CRTB_HOLD: begin
					stab_r <= '0;
					if (osc_ok_r) begin
						state_r <= crtb_pkg::CRTB_STAB; // RQ15
					end
				end
				crtb_pkg::CRTB_STAB: begin
					if (stab_r == SC_END) begin
						state_r <= crtb_pkg::CRTB_INIT; // RQ14
					end else begin
						stab_r <= stab_r + SC_W'(1); // RQ14
					end
				end
				crtb_pkg::CRTB_INIT: begin
					state_r <= crtb_pkg::CRTB_RUN; // RQ17
				end
				default: begin
					state_r <= crtb_pkg::CRTB_RUN;
				end
			endcase
		end
	end

	// Remember whether reset arrived while stopped
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			stop_seen_r <= 1'b0;
		end else if (any_reset && state_r == crtb_pkg::CRTB_RUN) begin
			stop_seen_r <= ctrl_r[crtb_pkg::CTRL_STOP_BIT]; // RQ13
		end
	end

	// Core-facing outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_core <= '{core_reset: 1'b1, nmi_context: 1'b1,
				stack_clear: 1'b1, pc_load: 1'b0,
				pullup_inputs: 1'b1, osc_restart: 1'b1};
			o_main_osc_on <= 1'b1;
			o_wdog_clear <= 1'b0;
			o_pc_load_value <= crtb_pkg::RESET_VECTOR;
			o_service_pending <= 1'b0;
		end else begin
			o_core.core_reset <= (state_r != crtb_pkg::CRTB_RUN); // RQ12 RQ15
			o_core.pullup_inputs <= (state_r != crtb_pkg::CRTB_RUN); // RQ12
			o_core.osc_restart <= any_reset; // RQ12 RQ13
			o_main_osc_on <= any_reset | ~ctrl_r[crtb_pkg::CTRL_STOP_BIT]
				| stop_seen_r; // RQ13
			o_core.stack_clear <= (state_r != crtb_pkg::CRTB_RUN); // RQ17
			o_core.pc_load <= (state_r == crtb_pkg::CRTB_INIT); // RQ17
			o_pc_load_value <= crtb_pkg::RESET_VECTOR; // RQ17
			o_wdog_clear <= i_wdog_timeout; // RQ16
			if (state_r != crtb_pkg::CRTB_RUN) begin
				o_core.nmi_context <= 1'b1; // RQ18
				o_service_pending <= 1'b0;
			end else if (return_from_interrupt_pulse && o_core.nmi_context) begin
				o_core.nmi_context <= 1'b0; // RQ18
				o_service_pending <= ctrl_r[crtb_pkg::CTRL_IRQ_PEND_BIT]
					| (osc_r.elapsed & osc_r.irq_en); // RQ19
			end else begin
				o_service_pending <= 1'b0;
			end
		end
	end

	// APB response
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= 1'b0;
			if (i_psel & ~i_penable) begin
				if (i_paddr == crtb_pkg::ADDR_STANDBY_OSC) begin
					o_prdata <= {24'h0, osc_r};
				end else if (i_paddr == crtb_pkg::ADDR_RESET_CTRL) begin
					o_prdata <= {28'h0, ctrl_r};
				end else if (i_paddr == crtb_pkg::ADDR_RESET_STAT) begin
					o_prdata <= {28'h0, o_core.nmi_context, stop_seen_r,
						state_r};
				end else begin
					o_prdata <= 32'h0;
					o_pslverr <= 1'b1;
				end
			end
		end
	end

	// Assertions
	property p_irq_level;
		@(posedge i_clk) disable iff (i_rst)
		1'b1 |=> (o_timebase_irq == $past(osc_r.elapsed & osc_r.irq_en));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq mismatch"); // RQ21

	property p_flag_sets;
		@(posedge i_clk) disable iff (i_rst)
		(tb_wrap && !any_reset) |=> osc_r.elapsed;
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("flag not set"); // RQ6

	property p_reset_clears;
		@(posedge i_clk) disable iff (i_rst)
		any_reset |=> (osc_r == crtb_pkg::STANDBY_OSC_RST);
	endproperty
	a_reset_clears: assert property (p_reset_clears) // RQ9
		else $error("osc reg not cleared");

	property p_div13;
		@(posedge i_clk) disable iff (i_rst)
		mc_tick |=> !mc_tick [*6] ##1 !mc_tick [*6] ##1 mc_tick;
	endproperty
	a_div13: assert property (p_div13) else $error("div13 wrong"); // RQ1

	property p_hold;
		@(posedge i_clk) disable iff (i_rst)
		any_reset |=> state_r == crtb_pkg::CRTB_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("reset not held"); // RQ11

	property p_stab_len;
		@(posedge i_clk) disable iff (i_rst)
		(state_r == crtb_pkg::CRTB_STAB && stab_r == '0 && !any_reset)
		|-> !(state_r == crtb_pkg::CRTB_INIT) [*8];
	endproperty
	a_stab_len: assert property (p_stab_len) else $error("delay short"); // RQ14

	property p_no_run_in_reset;
		@(posedge i_clk) disable iff (i_rst)
		(state_r != crtb_pkg::CRTB_RUN) |=> o_core.core_reset;
	endproperty
	a_no_run_in_reset: assert property (p_no_run_in_reset) // RQ15
		else $error("core ran in reset");

	property p_pc_load;
		@(posedge i_clk) disable iff (i_rst)
		(state_r == crtb_pkg::CRTB_INIT) |=> (o_core.pc_load
			&& o_pc_load_value == crtb_pkg::RESET_VECTOR);
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("no vector load"); // RQ17

	property p_nmi_after;
		@(posedge i_clk) disable iff (i_rst)
		(state_r == crtb_pkg::CRTB_INIT) |=> o_core.nmi_context;
	endproperty
	a_nmi_after: assert property (p_nmi_after) else $error("nmi ctx off"); // RQ18

	property p_lcd_gate;
		@(posedge i_clk) disable iff (i_rst)
		!osc_r.run |=> !o_lcd_clk;
	endproperty
	a_lcd_gate: assert property (p_lcd_gate) // RQ2
		else $error("lcd clock not gated");

	property p_tb_step;
		@(posedge i_clk) disable iff (i_rst)
		(!osc_r.run && mc_tick) |=> (tb_r == $past(tb_r) + TBW'(1));
	endproperty
	a_tb_step: assert property (p_tb_step) // RQ4
		else $error("timebase not on machine cycle");
endmodule : crtb_top

// ### crtb_ext.sv
// External reset circuit, power detector and oscillators
`timescale 1ns/10ps
module crtb_ext (
	input wire logic i_pin_low,
	input wire logic i_xtal_en,
	output logic o_reset_n,
	output logic o_por,
	output logic o_osc_ready,
	output logic o_xtal
);
	assign o_reset_n = !i_pin_low;
	initial begin
		o_por = 1'b1;
		o_osc_ready = 1'b0;
		o_xtal = 1'b0;
		#200 o_osc_ready = 1'b1;
		#100 o_por = 1'b0;
	end
	// Crystal stands still while stopped
	always #20 o_xtal = i_xtal_en ? !o_xtal : o_xtal;
endmodule : crtb_ext

// ### clock_reset_timebase_tb.sv
// Self-checking bench for the clock, reset and timebase block
`timescale 1ns/10ps
module clock_reset_timebase_tb;
	localparam int STAB = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic wdog = 1'b0;
	logic pin_low = 1'b0;
	logic xtal_en = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, rst_n, por, osc_rdy, xtal;
	logic mclk, cclk, lclk, irq, wclr, osc_on, pend;
	logic [11:0] pcv;
	crtb_pkg::crtb_core_t core;
	int n_fail = 0;
	int n_checks = 0;
	int n, m;
	logic [31:0] rnd = 32'h615d8152;
	logic [31:0] q;
	logic e;
	logic [7:0] osc_m;
	logic xout;
	int exp_q[$];
	always #5 clk = !clk;
	crtb_ext i_crtb_ext (.i_pin_low(pin_low), .i_xtal_en(xtal_en),
		.o_reset_n(rst_n), .o_por(por), .o_osc_ready(osc_rdy),
		.o_xtal(xtal));
	crtb_top #(.STAB_COUNT(STAB)) i_crtb_top (.i_clk(clk), .i_rst(rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_reset_n(rst_n),
		.i_por(por), .i_osc_ready(osc_rdy), .i_wdog_timeout(wdog),
		.i_standby_xtal_input(xtal), .o_standby_xtal_output(xout),
		.o_machine_clk(mclk), .o_conv_clk(cclk), .o_lcd_clk(lclk),
		.o_timebase_irq(irq), .o_wdog_clear(wclr),
		.o_main_osc_on(osc_on), .o_core(core), .o_pc_load_value(pcv),
		.o_service_pending(pend));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic sig(input int s);
		case (s)
			0: return core.core_reset;
			1: return pend;
			2: return irq;
			3: return mclk;
			4: return cclk;
			default: return lclk;
		endcase
	endfunction : sig
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic chk32(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask : chk32
	task automatic chk1(input logic g, input logic x);
		chk32({31'h0, g}, {31'h0, x});
	endtask : chk1
	task automatic wt(input int s, input logic v, input int lim,
		output int k);
		k = 0;
		while (sig(s) !== v) begin
			@(posedge clk);
			k++;
			if (k > lim) begin
				n_fail++;
				$display("unexpected at %0t: wait ran out", $time);
				test_done();
			end
		end
	endtask : wt
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		if (k >= 50) begin
			n_fail++;
			$display("unexpected at %0t: no bus answer", $time);
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0);
		chk32(q, {24'h0, x});
	endtask : rd
	task automatic wosc(input logic [7:0] d);
		apb(1'b1, crtb_pkg::ADDR_STANDBY_OSC, {24'h0, d});
		osc_m = {d[7], osc_m[6] & d[6], d[5:0]};
	endtask : wosc
	task automatic per(input int s);
		wt(s, 1'b0, 30, n);
		wt(s, 1'b1, 30, n);
		wt(s, 1'b0, 30, n);
		wt(s, 1'b1, 30, m);
		n = n + m;
	endtask : per
	initial begin
		osc_m = crtb_pkg::STANDBY_OSC_RST;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk1(core.core_reset, 1'b1);
		chk1(core.stack_clear, 1'b1);
		wt(0, 1'b0, 300, n);
		rd(crtb_pkg::ADDR_STANDBY_OSC, 8'h00);
		chk32({20'h0, pcv}, 32'hffe);
		chk1(core.nmi_context, 1'b1);
		exp_q.push_back(crtb_pkg::CORE_DIV);
		exp_q.push_back(crtb_pkg::CONV_DIV);
		per(3);
		chk32(n, exp_q.pop_front());
		per(4);
		chk32(n, exp_q.pop_front());
		rnd = lfsr(rnd);
		apb(1'b1, 12'h0f0, rnd);
		chk1(e, 1'b1);
		rd(12'h0f0, 8'h00);
		chk1(e, 1'b1);
		apb(1'b1, crtb_pkg::ADDR_RESET_CTRL, 32'h2);
		apb(1'b1, crtb_pkg::ADDR_RESET_CTRL, 32'h3);
		wt(1, 1'b1, 8, n);
		chk1(pend, 1'b1);
		@(posedge clk);
		chk1(core.nmi_context, 1'b0);
		xtal_en <= 1'b1;
		wosc(8'ha0);
		rd(crtb_pkg::ADDR_STANDBY_OSC, osc_m);
		wt(5, 1'b1, 20, m);
		chk1(xout, 1'b0);
		wt(2, 1'b1, 70000, n);
		chk1(n > 65000 && n < 65600, 1'b1);
		osc_m[crtb_pkg::ELAPSED_BIT] = 1'b1;
		rd(crtb_pkg::ADDR_STANDBY_OSC, osc_m);
		wosc(8'h60);
		@(posedge clk);
		chk1(irq, 1'b0);
		wosc(8'he0);
		@(posedge clk);
		chk1(irq, 1'b1);
		wosc(8'ha0);
		rd(crtb_pkg::ADDR_STANDBY_OSC, osc_m);
		chk1(irq, 1'b0);
		xtal_en <= 1'b0;
		wdog <= 1'b1;
		@(posedge clk);
		wdog <= 1'b0;
		@(posedge clk);
		chk1(wclr, 1'b1);
		wt(0, 1'b1, 4, n);
		wt(0, 1'b0, 300, n);
		rd(crtb_pkg::ADDR_STANDBY_OSC, 8'h00);
		chk1(core.nmi_context, 1'b1);
		wosc(8'h00);
		chk1(xout, 1'b0);
		apb(1'b1, crtb_pkg::ADDR_RESET_CTRL, 32'h4);
		rnd = lfsr(rnd);
		pin_low <= 1'b1;
		repeat (2 + rnd[1:0]) @(posedge clk);
		pin_low <= 1'b0;
		wt(0, 1'b1, 8, n);
		chk1(core.pullup_inputs, 1'b1);
		chk1(osc_on, 1'b1);
		chk1(core.osc_restart, 1'b1);
		wt(0, 1'b0, 300, n);
		chk1(n >= STAB && n <= STAB + 12, 1'b1);
		test_done();
	end
endmodule : clock_reset_timebase_tb
